// File: hw/scfh_cmd_handler.v
// Command-frame handler: frame decode, replies, push and acquisition timing
`timescale 1ns/1ns
`default_nettype none
`include "scfh_defs.vh"

// Behaviour
// - Config write answered with empty frame 19
// - Filter write answered with empty frame 20
// - Frame 21 starts periodic push output
// - Frame 22 stops periodic push output
// - Leaving sleep sends empty frame 23
// - Frame 24: poll, flush, spacing, gap
// - Poll flag true polls; default poll
// - Flush flag voids filter each reading
// - Spacing sets acquisition period; zero immediate
// - Push waits gap after each set
// - Short gap resends latest data unchanged
// - Frame 25 queries acquisition parameters
// - Acquisition write answered with frame 26
// - Query answered by frame 27, same layout
// - Sleep request: send 28, then sleep
// - Frame 29 restores factory magnetic calibration
// - Magnetic restore answered with frame 30
// - Frame 31 takes guarded manual calibration sample
// - Frame 36 clears user accelerometer calibration
// - Accelerometer clear answered with frame 37
// - Any character wakes sleeping device
// - Persist reply code 0000 ok, 0001 fail
module scfh_cmd_handler #(
  parameter CLK_HZ = `SCFH_CLK_HZ
) (
  input  wire        mclk,              // System clock
  input  wire        rst_b,             // Async reset, low
  input  wire [7:0]  reg_addr,          // Register byte address
  input  wire [31:0] reg_wdata,         // Register write data
  input  wire        reg_wr,            // Write strobe
  input  wire        reg_rd,            // Read strobe
  output reg  [31:0] reg_rdata,         // Read data, next cycle
  input  wire        rx_valid,          // Received byte valid
  input  wire [7:0]  rx_data,           // Received byte
  input  wire        rx_last,           // Last byte of frame
  output reg         rx_ready,          // Handler takes bytes
  output reg         tx_valid,          // Reply byte valid
  output reg  [7:0]  tx_data,           // Reply byte
  output reg         tx_last,           // Last reply byte
  input  wire        tx_ready,          // Framer takes byte
  output reg         acq_start,         // Start one acquisition
  input  wire        acq_done,          // Acquisition finished
  output reg         filter_flush,      // Void filter contents
  output reg         push_send,         // Send latest data set
  input  wire        push_sent,         // Data set fully sent
  output reg         nvm_save,          // Start persist write
  input  wire        nvm_done,          // Persist write over
  input  wire        nvm_fail,          // Persist write failed
  output reg         mag_cal_restore,   // Load factory mag coeffs
  output reg         accel_cal_clear,   // Clear user accel coeffs
  output reg         cal_sample,        // Take calibration sample
  input  wire        cal_active,        // Field calibration running
  input  wire        auto_cal_sampling, // Automatic sampling on
  input  wire        cal_stability_check, // Stability met
  output reg         sleep              // Device asleep
);

  localparam [1:0] A_IDLE = 2'd0;
  localparam [1:0] A_BUSY = 2'd1;
  localparam [1:0] A_WAIT = 2'd2;
  localparam [1:0] P_OFF  = 2'd0;
  localparam [1:0] P_SENT = 2'd1;
  localparam [1:0] P_GAP  = 2'd2;

  reg         poll_select_flag_r;
  reg         filter_clear_flag_r;
  reg  [31:0] sample_spacing_r;
  reg  [31:0] push_gap_r;
  reg         in_frame_r;
  reg  [7:0]  id_r;
  reg  [3:0]  cnt_r;
  reg  [71:0] pbuf_r;
  reg  [7:0]  rep_id_r;
  reg  [79:0] tx_sh_r;
  reg  [3:0]  tx_left_r;
  reg         save_wait_r;
  reg         save_err_r;
  reg         cmd_start_r;
  reg         cmd_stop_r;
  reg  [1:0]  acq_st_r;
  reg  [31:0] acq_cnt_r;
  reg  [31:0] acq_total_r;
  reg  [1:0]  push_st_r;
  reg  [31:0] gap_cnt_r;
  reg  [31:0] rdata_nxt;

  wire [31:0] spacing_cyc;
  wire [31:0] gap_cyc;

  // ---------------------------------------------------------------
  // Seconds to cycles for spacing and gap
  // ---------------------------------------------------------------
  scfh_sec2cyc #(.CLK_HZ(CLK_HZ)) u_spacing (
    .sec_f  (sample_spacing_r),
    .cycles (spacing_cyc)
  );

  scfh_sec2cyc #(.CLK_HZ(CLK_HZ)) u_gap (
    .sec_f  (push_gap_r),
    .cycles (gap_cyc)
  );

  // ---------------------------------------------------------------
  // Frame decode helpers
  // ---------------------------------------------------------------
  wire        rx_acc = rx_valid & rx_ready;
  wire [7:0]  fid    = in_frame_r ? id_r : rx_data;
  wire [3:0]  plen   = in_frame_r ? cnt_r + 4'h1 : 4'h0;
  wire [79:0] pnext  = {pbuf_r, rx_data};
  wire        tx_adv = tx_valid & tx_ready;
  wire        slp_pend = tx_valid & (rep_id_r == `SCFH_ID_SLEEP_ACK);
  // Parameter image for the query reply, in the write frame's layout
  wire [79:0] acq_vec = {7'h00, poll_select_flag_r, 7'h00, filter_clear_flag_r,
                         sample_spacing_r, push_gap_r};

  // Load a reply frame; the handler stops taking bytes meanwhile
  task start_tx;
    input [7:0]  id;
    input [3:0]  len;
    input [79:0] pay;
    begin
      rep_id_r  <= id;
      tx_valid  <= 1'b1;
      tx_data   <= id;
      tx_last   <= (len == 4'h0);
      tx_left_r <= len;
      tx_sh_r   <= pay;
      rx_ready  <= 1'b0;
    end
  endtask

  // ---------------------------------------------------------------
  // Frame intake, command decode and reply sender
  // ---------------------------------------------------------------
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      poll_select_flag_r  <= `SCFH_RST_POLL;
      filter_clear_flag_r <= `SCFH_RST_FLUSH;
      sample_spacing_r    <= `SCFH_RST_SPACING;
      push_gap_r          <= `SCFH_RST_GAP;
      in_frame_r          <= 1'b0;
      id_r                <= 8'h00;
      cnt_r               <= 4'h0;
      pbuf_r              <= 72'h0;
      rep_id_r            <= 8'h00;
      tx_sh_r             <= 80'h0;
      tx_left_r           <= 4'h0;
      tx_valid            <= 1'b0;
      tx_data             <= 8'h00;
      tx_last             <= 1'b0;
      rx_ready            <= 1'b1;
      save_wait_r         <= 1'b0;
      save_err_r          <= 1'b0;
      cmd_start_r         <= 1'b0;
      cmd_stop_r          <= 1'b0;
      nvm_save            <= 1'b0;
      mag_cal_restore     <= 1'b0;
      accel_cal_clear     <= 1'b0;
      cal_sample          <= 1'b0;
      sleep               <= 1'b0;
    end else begin
      cmd_start_r     <= 1'b0;
      cmd_stop_r      <= 1'b0;
      nvm_save        <= 1'b0;
      mag_cal_restore <= 1'b0;
      accel_cal_clear <= 1'b0;
      cal_sample      <= 1'b0;
      // Software writes to the acquisition parameters
      if (reg_wr) begin
        case (reg_addr)
          `SCFH_REG_ACQ_CTRL: begin
            poll_select_flag_r  <= reg_wdata[`SCFH_BIT_POLL];
            filter_clear_flag_r <= reg_wdata[`SCFH_BIT_FLUSH];
          end
          `SCFH_REG_SPACING: sample_spacing_r <= reg_wdata;
          `SCFH_REG_GAP:     push_gap_r <= reg_wdata;
          default: ;
        endcase
      end
      // Reply bytes leave one per accepted handshake
      if (tx_adv) begin
        if (tx_last) begin
          tx_valid <= 1'b0;
          rx_ready <= 1'b1;
          if (rep_id_r == `SCFH_ID_SLEEP_ACK) begin
            sleep <= 1'b1;
          end
        end else begin
          tx_data   <= tx_sh_r[79:72];
          tx_sh_r   <= {tx_sh_r[71:0], 8'h00};
          tx_left_r <= tx_left_r - 4'h1;
          tx_last   <= (tx_left_r == 4'h1);
        end
      end
      // Persist finished: reply with result code
      if (save_wait_r && nvm_done) begin
        save_wait_r <= 1'b0;
        save_err_r  <= nvm_fail;
        start_tx(`SCFH_ID_PERSIST_REP, `SCFH_PERSIST_LEN,
                 {(nvm_fail ? `SCFH_SAVE_FAIL : `SCFH_SAVE_OK), 64'h0});
      end
      if (sleep) begin
        // Any character wakes; it is consumed, not parsed
        if (rx_acc) begin
          sleep      <= 1'b0;
          in_frame_r <= 1'b0;
          start_tx(`SCFH_ID_WAKE, 4'h0, 80'h0);
        end
      end else if (rx_acc) begin
        in_frame_r <= ~rx_last;
        if (in_frame_r) begin
          pbuf_r <= pnext[71:0];
          if (cnt_r != 4'hE) begin
            cnt_r <= cnt_r + 4'h1;
          end
        end else begin
          id_r  <= rx_data;
          cnt_r <= 4'h0;
        end
        if (rx_last) begin
          case (fid)
            `SCFH_ID_CONFIG_WR: begin
              start_tx(`SCFH_ID_CONFIG_ACK, 4'h0, 80'h0);
            end
            `SCFH_ID_FILT_WR: begin
              start_tx(`SCFH_ID_FILT_ACK, 4'h0, 80'h0);
            end
            `SCFH_ID_PUSH_START: begin
              if (plen == 4'h0 && !poll_select_flag_r) begin
                cmd_start_r <= 1'b1;
              end
            end
            `SCFH_ID_PUSH_STOP: begin
              if (plen == 4'h0) begin
                cmd_stop_r <= 1'b1;
              end
            end
            `SCFH_ID_ACQ_WR: begin
              if (plen == `SCFH_ACQ_LEN) begin
                poll_select_flag_r  <= (pnext[79:72] != 8'h00);
                filter_clear_flag_r <= (pnext[71:64] != 8'h00);
                sample_spacing_r    <= pnext[63:32];
                push_gap_r          <= pnext[31:0];
                start_tx(`SCFH_ID_ACQ_ACK, 4'h0, 80'h0);
              end
            end
            `SCFH_ID_ACQ_QUERY: begin
              if (plen == 4'h0) begin
                start_tx(`SCFH_ID_ACQ_REPLY, `SCFH_ACQ_LEN, acq_vec);
              end
            end
            `SCFH_ID_SLEEP_REQ: begin
              start_tx(`SCFH_ID_SLEEP_ACK, 4'h0, 80'h0);
            end
            `SCFH_ID_PERSIST: begin
              nvm_save    <= 1'b1;
              save_wait_r <= 1'b1;
              rx_ready    <= 1'b0;
            end
            `SCFH_ID_MAG_RESTORE: begin
              mag_cal_restore <= 1'b1;
              start_tx(`SCFH_ID_MAG_ACK, 4'h0, 80'h0);
            end
            `SCFH_ID_CAL_SAMPLE: begin
              if (cal_active && !auto_cal_sampling && cal_stability_check) begin
                cal_sample <= 1'b1;
              end
            end
            `SCFH_ID_ACCEL_CLEAR: begin
              accel_cal_clear <= 1'b1;
              start_tx(`SCFH_ID_ACCEL_ACK, 4'h0, 80'h0);
            end
            default: ;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Internal acquisition pacing
  // ---------------------------------------------------------------
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      acq_st_r     <= A_IDLE;
      acq_cnt_r    <= 32'h00000000;
      acq_total_r  <= 32'h00000000;
      acq_start    <= 1'b0;
      filter_flush <= 1'b0;
    end else begin
      acq_start    <= 1'b0;
      filter_flush <= 1'b0;
      case (acq_st_r)
        A_IDLE: begin
          if (!sleep && !slp_pend) begin
            acq_start <= 1'b1;
            acq_st_r  <= A_BUSY;
          end
        end
        A_BUSY: begin
          if (acq_done) begin
            filter_flush <= filter_clear_flag_r;
            acq_total_r  <= acq_total_r + 32'h00000001;
            acq_cnt_r    <= spacing_cyc;
            acq_st_r     <= A_WAIT;
          end
        end
        A_WAIT: begin
          // Zero spacing restarts at once
          if (acq_cnt_r == 32'h00000000) begin
            acq_st_r <= A_IDLE;
          end else begin
            acq_cnt_r <= acq_cnt_r - 32'h00000001;
          end
        end
        default: acq_st_r <= A_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Push output pacing
  // ---------------------------------------------------------------
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      push_st_r <= P_OFF;
      gap_cnt_r <= 32'h00000000;
      push_send <= 1'b0;
    end else begin
      push_send <= 1'b0;
      if (cmd_stop_r || sleep || slp_pend) begin
        push_st_r <= P_OFF;
      end else begin
        case (push_st_r)
          P_OFF: begin
            if (cmd_start_r) begin
              push_send <= 1'b1;
              push_st_r <= P_SENT;
            end
          end
          P_SENT: begin
            if (push_sent) begin
              gap_cnt_r <= gap_cyc;
              push_st_r <= P_GAP;
            end
          end
          P_GAP: begin
            // Latest data goes out whether fresh or not
            if (gap_cnt_r == 32'h00000000) begin
              push_send <= 1'b1;
              push_st_r <= P_SENT;
            end else begin
              gap_cnt_r <= gap_cnt_r - 32'h00000001;
            end
          end
          default: push_st_r <= P_OFF;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  always @* begin
    rdata_nxt = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        `SCFH_REG_STATUS: begin
          rdata_nxt[`SCFH_BIT_SLEEP]    = sleep;
          rdata_nxt[`SCFH_BIT_PUSH_ON]  = (push_st_r != P_OFF);
          rdata_nxt[`SCFH_BIT_BUSY]     = ~rx_ready;
          rdata_nxt[`SCFH_BIT_SAVE_ERR] = save_err_r;
        end
        `SCFH_REG_ACQ_CTRL: begin
          rdata_nxt[`SCFH_BIT_POLL]  = poll_select_flag_r;
          rdata_nxt[`SCFH_BIT_FLUSH] = filter_clear_flag_r;
        end
        `SCFH_REG_SPACING:   rdata_nxt = sample_spacing_r;
        `SCFH_REG_GAP:       rdata_nxt = push_gap_r;
        `SCFH_REG_ACQ_COUNT: rdata_nxt = acq_total_r;
        default:             rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Read data stands one cycle only
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

endmodule // scfh_cmd_handler
`default_nettype wire

// File: include/scfh_defs.vh
// Constants for the sensor command-frame handler
`ifndef SCFH_DEFS_VH
`define SCFH_DEFS_VH

// Clock rate in Hz
`define SCFH_CLK_HZ         125000000

// Frame identifiers received
`define SCFH_ID_CONFIG_WR   8'h06
`define SCFH_ID_PERSIST     8'h09
`define SCFH_ID_FILT_WR     8'h0C
`define SCFH_ID_SLEEP_REQ   8'h0F
`define SCFH_ID_PUSH_START  8'h15
`define SCFH_ID_PUSH_STOP   8'h16
`define SCFH_ID_ACQ_WR      8'h18
`define SCFH_ID_ACQ_QUERY   8'h19
`define SCFH_ID_MAG_RESTORE 8'h1D
`define SCFH_ID_CAL_SAMPLE  8'h1F
`define SCFH_ID_ACCEL_CLEAR 8'h24

// Frame identifiers sent
`define SCFH_ID_PERSIST_REP 8'h10
`define SCFH_ID_CONFIG_ACK  8'h13
`define SCFH_ID_FILT_ACK    8'h14
`define SCFH_ID_WAKE        8'h17
`define SCFH_ID_ACQ_ACK     8'h1A
`define SCFH_ID_ACQ_REPLY   8'h1B
`define SCFH_ID_SLEEP_ACK   8'h1C
`define SCFH_ID_MAG_ACK     8'h1E
`define SCFH_ID_ACCEL_ACK   8'h25

// Payload lengths in bytes
`define SCFH_ACQ_LEN        4'hA
`define SCFH_PERSIST_LEN    4'h2

// Persist result codes
`define SCFH_SAVE_OK        16'h0000
`define SCFH_SAVE_FAIL      16'h0001

// Register offsets
`define SCFH_REG_STATUS     8'h00
`define SCFH_REG_ACQ_CTRL   8'h04
`define SCFH_REG_SPACING    8'h08
`define SCFH_REG_GAP        8'h0C
`define SCFH_REG_ACQ_COUNT  8'h10

// Field positions
`define SCFH_BIT_POLL       0
`define SCFH_BIT_FLUSH      1
`define SCFH_BIT_SLEEP      0
`define SCFH_BIT_PUSH_ON    1
`define SCFH_BIT_BUSY       2
`define SCFH_BIT_SAVE_ERR   3

// Reset values
`define SCFH_RST_POLL       1'b1
`define SCFH_RST_FLUSH      1'b0
`define SCFH_RST_SPACING    32'h00000000
`define SCFH_RST_GAP        32'h00000000

`endif

// File: hw/scfh_sec2cyc.v
// Float32 seconds to clock-cycle count converter
`timescale 1ns/1ns
`default_nettype none
`include "scfh_defs.vh"

module scfh_sec2cyc #(
  parameter CLK_HZ = `SCFH_CLK_HZ
) (
  input  wire [31:0] sec_f,  // Seconds, IEEE single
  output reg  [31:0] cycles  // Whole cycles, saturated
);

  localparam [26:0] CLKW = CLK_HZ[26:0];

  // ---------------------------------------------------------------
  // Mantissa times clock rate, scaled by exponent
  // ---------------------------------------------------------------
  wire [7:0]  expo = sec_f[30:23];
  wire [23:0] mant = {1'b1, sec_f[22:0]};
  wire [50:0] prod = mant * CLKW;
  wire [7:0]  rsh  = 8'd150 - expo;
  wire [50:0] shr  = prod >> rsh;

  // Negative, zero and tiny give zero; huge saturates; rounds down
  always @* begin
    if (sec_f[31] || expo == 8'h00 || expo < 8'd99) begin
      cycles = 32'h00000000;
    end else if (expo > 8'd150 || shr[50:32] != 19'h00000) begin
      cycles = 32'hFFFFFFFF;
    end else begin
      cycles = shr[31:0];
    end
  end

endmodule // scfh_sec2cyc
`default_nettype wire

// File: test/scfh_cmd_handler_asserts.sv
// Port checker for the command-frame handler
`timescale 1ns/1ns
`default_nettype none
module scfh_chk (
  input wire logic       mclk,                // Clock
  input wire logic       rst_b,               // Reset, low
  input wire logic       rx_valid,            // Byte offered
  input wire logic [7:0] rx_data,             // Byte value
  input wire logic       rx_last,             // Frame end
  input wire logic       rx_ready,            // Byte taken
  input wire logic       tx_valid,            // Reply byte
  input wire logic [7:0] tx_data,             // Reply value
  input wire logic       tx_last,             // Reply end
  input wire logic       tx_ready,            // Reply taken
  input wire logic       acq_start,           // Acquire
  input wire logic       acq_done,            // Acquired
  input wire logic       filter_flush,        // Void filter
  input wire logic       push_send,           // Push set
  input wire logic       mag_cal_restore,     // Mag restore
  input wire logic       accel_cal_clear,     // Accel clear
  input wire logic       cal_sample,          // Cal sample
  input wire logic       cal_active,          // Cal running
  input wire logic       auto_cal_sampling,   // Auto sampling
  input wire logic       cal_stability_check, // Stable
  input wire logic       sleep                // Asleep
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic mid_r;
  // Frame position
  always @(posedge mclk or negedge rst_b)
    if (!rst_b) mid_r <= 1'b0;
    else if (rx_valid && rx_ready) mid_r <= !rx_last && !sleep;
  // ----------------------------------------
  // Reply framing and command side effects
  // ----------------------------------------
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("reply byte changed while stalled");
  a_empty_acks: assert property ($rose(tx_valid) && (tx_data inside {8'h13, 8'h14, 8'h17, 8'h1A, 8'h1C, 8'h1E, 8'h25})
    |-> tx_last) else $error("acknowledge frame carries payload");
  a_query_reply: assert property (!mid_r && !sleep && rx_valid && rx_ready && rx_last && rx_data == 8'h19
    |=> tx_valid && tx_data == 8'h1B) else $error("query not answered next cycle");
  a_flush_cause: assert property (filter_flush |-> $past(acq_done))
    else $error("filter flush without finished acquisition");
  a_sleep_entry: assert property ($rose(sleep) |-> $past(tx_valid && tx_ready && tx_last && tx_data == 8'h1C))
    else $error("sleep entered before its acknowledge was sent");
  a_wake_notice: assert property ($fell(sleep) |-> tx_valid && tx_last && tx_data == 8'h17)
    else $error("wake without wake notice");
  a_sleep_quiet: assert property (sleep |-> !tx_valid && !acq_start && !push_send)
    else $error("activity while asleep");
  a_cal_guard: assert property (cal_sample |-> $past(cal_active && !auto_cal_sampling && cal_stability_check))
    else $error("calibration sample without its conditions");
  a_mag_ack: assert property ($rose(tx_valid) && tx_data == 8'h1E
    |-> mag_cal_restore || $past(mag_cal_restore) || $past(mag_cal_restore, 2)) else $error("mag ack without restore");
  a_accel_ack: assert property ($rose(tx_valid) && tx_data == 8'h25
    |-> accel_cal_clear || $past(accel_cal_clear) || $past(accel_cal_clear, 2)) else $error("accel ack without clear");
endmodule // scfh_chk

bind scfh_cmd_handler scfh_chk u_chk (.mclk(mclk), .rst_b(rst_b), .rx_valid(rx_valid), .rx_data(rx_data),
  .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
  .tx_ready(tx_ready), .acq_start(acq_start), .acq_done(acq_done), .filter_flush(filter_flush),
  .push_send(push_send), .mag_cal_restore(mag_cal_restore), .accel_cal_clear(accel_cal_clear),
  .cal_sample(cal_sample), .cal_active(cal_active), .auto_cal_sampling(auto_cal_sampling),
  .cal_stability_check(cal_stability_check), .sleep(sleep));
`default_nettype wire

// File: test/scfh_host.sv
// Host model: sends command frames, collects reply frames
`timescale 1ns/1ns
`default_nettype none
module scfh_host (
  input  wire logic       mclk,     // Clock
  output var  logic       rx_valid, // Byte offered
  output var  logic [7:0] rx_data,  // Byte value
  output var  logic       rx_last,  // Frame end
  input  wire logic       rx_ready, // Handler takes
  input  wire logic       tx_valid, // Reply byte
  input  wire logic [7:0] tx_data,  // Reply value
  input  wire logic       tx_last,  // Reply end
  output var  logic       tx_ready, // Model takes
  input  wire logic       slow      // Stall alternate cycles
);
  logic [7:0] txq[$]; // Reply bytes
  int         nlast;  // Replies done
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    nlast = 0;
  end
  // ---------------------------------
  // Frame out, id first, payload MSB first
  // ---------------------------------
  task automatic send(input logic [7:0] id, input int n, input logic [79:0] p);
    for (int i = 0; i <= n; i++) begin
      rx_valid <= 1'b1;
      rx_data <= (i == 0) ? id : p[8*(n-i) +: 8];
      rx_last <= (i == n);
      do @(posedge mclk); while (!rx_ready);
    end
    rx_valid <= 1'b0;
    rx_data <= ~rx_data; // Released line shows no stale byte
    rx_last <= 1'b0;
  endtask
  // Reply sink; every accepted reply byte is queued
  always @(posedge mclk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready) begin
      txq.push_back(tx_data);
      if (tx_last) nlast <= nlast + 1;
    end
  end
endmodule // scfh_host
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the command-frame handler
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        acq_done = 1'b0, push_sent = 1'b0, nvm_done = 1'b0, nvm_fail = 1'b0;
  logic        cal_act = 1'b0, auto_cal = 1'b0, stab = 1'b0;
  logic [3:0]  acq_sh = 4'h0, push_sh = 4'h0, nvm_sh = 4'h0;
  wire  [31:0] reg_rdata;
  wire  [7:0]  rx_data, tx_data;
  wire         rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, acq_start, filter_flush;
  wire         push_send, nvm_save, mag_cal_restore, accel_cal_clear, cal_sample, sleep;
  int          num_errors = 0, total_checks = 0, cyc = 0, k = 0;
  int          n_push = 0, n_flush = 0, n_mag = 0, n_acc = 0, n_cal = 0, n_acqd = 0;
  localparam logic [79:0] acq_pay = 80'h0001_33D6BF95_00000000;

  always #4 mclk = ~mclk;

  scfh_cmd_handler dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .acq_start(acq_start), .acq_done(acq_done), .filter_flush(filter_flush),
    .push_send(push_send), .push_sent(push_sent), .nvm_save(nvm_save), .nvm_done(nvm_done),
    .nvm_fail(nvm_fail), .mag_cal_restore(mag_cal_restore), .accel_cal_clear(accel_cal_clear),
    .cal_sample(cal_sample), .cal_active(cal_act), .auto_cal_sampling(auto_cal),
    .cal_stability_check(stab), .sleep(sleep));
  scfh_host host (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .slow(slow));

  // Far-end responders, pulse counters, hang limit
  always @(posedge mclk) begin
    acq_sh <= {acq_sh[2:0], acq_start};
    push_sh <= {push_sh[2:0], push_send};
    nvm_sh <= {nvm_sh[2:0], nvm_save};
    acq_done <= acq_sh[3];
    push_sent <= push_sh[1];
    nvm_done <= nvm_sh[3];
    n_push <= n_push + push_send;
    n_flush <= n_flush + filter_flush;
    n_mag <= n_mag + mag_cal_restore;
    n_acc <= n_acc + accel_cal_clear;
    n_cal <= n_cal + cal_sample;
    n_acqd <= n_acqd + acq_done;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  // ---------------------------------
  // Access tasks
  // ---------------------------------
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] e);
    total_checks++;
    if (seen !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", w, e, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    check(w, reg_rdata, e);
  endtask
  // Sends a frame; a zero reply id means no reply may come
  task automatic xfer(input logic [7:0] id, input int n, input logic [79:0] p,
                      input logic [7:0] rid, input int rn, input logic [79:0] rp);
    int t;
    int n0;
    n0 = host.nlast;
    host.txq.delete();
    host.send(id, n, p);
    t = 0;
    while (host.nlast == n0 && t < 200) begin
      @(posedge mclk);
      t++;
    end
    check("reply length", host.txq.size(), (rid == 8'h00) ? 0 : rn + 1);
    if (rid != 8'h00) check("reply id", host.txq[0], rid);
    for (int i = 1; i <= rn; i++) check("reply byte", host.txq[i], rp[8*(rn-i) +: 8]);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ---------------------------------
  // Test sequence
  // ---------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd(8'h04, 32'h1, "flags at reset");
    rd(8'h08, 32'h0, "spacing at reset");
    rd(8'h0C, 32'h0, "gap at reset");
    rd(8'h14, 32'h0, "unmapped read");
    xfer(8'h06, 2, 80'hABCD, 8'h13, 0, 0);
    xfer(8'h0C, 3, 80'h030100, 8'h14, 0, 0);
    xfer(8'h20, 0, 0, 8'h00, 0, 0);
    xfer(8'h15, 0, 0, 8'h00, 0, 0);
    check("no push while polled", n_push, 0);
    xfer(8'h18, 10, acq_pay, 8'h1A, 0, 0);
    slow <= 1'b1;
    xfer(8'h19, 0, 0, 8'h1B, 10, acq_pay);
    slow <= 1'b0;
    rd(8'h04, 32'h2, "flags after write");
    rd(8'h08, 32'h33D6BF95, "spacing after write");
    check("flush pulses", n_flush > 0, 32'h1);
    wr(8'h08, 32'h3F800000);
    xfer(8'h15, 0, 0, 8'h00, 0, 0);
    check("push repeats stale data", n_push > 5, 32'h1);
    rd(8'h00, 32'h2, "push status");
    xfer(8'h16, 0, 0, 8'h00, 0, 0);
    k = n_push;
    repeat (20) @(posedge mclk);
    check("push stopped", n_push, k);
    rd(8'h10, n_acqd, "acq count");
    cal_act <= 1'b1;
    auto_cal <= 1'b1;
    stab <= 1'b1;
    xfer(8'h1F, 0, 0, 8'h00, 0, 0);
    auto_cal <= 1'b0;
    stab <= 1'b0;
    xfer(8'h1F, 0, 0, 8'h00, 0, 0);
    check("guarded sample", n_cal, 0);
    stab <= 1'b1;
    xfer(8'h1F, 0, 0, 8'h00, 0, 0);
    check("manual sample", n_cal, 1);
    xfer(8'h1D, 0, 0, 8'h1E, 0, 0);
    xfer(8'h24, 0, 0, 8'h25, 0, 0);
    check("restore and clear", {n_mag[7:0], n_acc[7:0]}, 32'h0101);
    nvm_fail <= 1'b1;
    xfer(8'h09, 0, 0, 8'h10, 2, 80'h1);
    nvm_fail <= 1'b0;
    xfer(8'h09, 0, 0, 8'h10, 2, 80'h0);
    xfer(8'h0F, 0, 0, 8'h1C, 0, 0);
    rd(8'h00, 32'h1, "asleep status");
    xfer(8'hFF, 0, 0, 8'h17, 0, 0);
    rd(8'h00, 32'h0, "awake status");
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd(8'h04, 32'h1, "flags after second reset");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
